// ==== odac_core.sv ====
// odac_core: top of the octal dac command decoder; registers, shutdown and phase
// assumes: host shifts exactly 16 bits per device per frame, then raises chip select
// the command word is stable in the link domain once chip select is high, so it is
// captured in the core domain after the synchronised rising edge of chip select.
`timescale 1ns/1ps
module odac_core
  import odac_pkg::*;
#(
  parameter int CHANNELS = ODAC_CHANNELS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic csN,
  input wire logic sdi,
  input wire logic hw_load_n,
  output logic sdo,
  output logic [CHANNELS*8-1:0] dacCode,
  output logic [CHANNELS*8-1:0] inputCode,
  output logic [CHANNELS-1:0] bufferEnable,
  output logic shutdown,
  output logic phaseRise
);
  typedef enum logic [2:0] {
    ODAC_IDLE = 3'b001,
    ODAC_FRAME = 3'b010,
    ODAC_EXEC = 3'b100
  } odac_state_e;

  logic [15:0] shiftWord;
  logic csLevel;
  logic loadLevel;
  logic phaseSclk1;
  logic phaseSclk2;
  odac_state_e state;
  odac_state_e next_state;
  odac_cmd_s cmd;
  logic [7:0] inReg [CHANNELS];
  logic [7:0] dacReg [CHANNELS];
  logic [CHANNELS-1:0] bufMask;

  // link side: shift register and serial output on sclk
  odac_link uLink (
    .sclk(sclk),
    .rst_n(rst_n),
    .csN(csN),
    .sdi(sdi),
    .phaseRise(phaseSclk2),
    .sdo(sdo),
    .shiftWord(shiftWord)
  );

  // phase level crosses into sclk domain by two flops
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      phaseSclk1 <= ODAC_PHASE_RST;
      phaseSclk2 <= ODAC_PHASE_RST;
    end else begin
      phaseSclk1 <= phaseRise;
      phaseSclk2 <= phaseSclk1;
    end
  end

  // chip select pin into clk domain; idles high
  odac_sync #(.RESET_VALUE(1'b1)) uCsSync (
    .clk(clk),
    .rst_n(rst_n),
    .pinIn(csN),
    .levelOut(csLevel)
  );

  // hardware load pin; idles high (not transparent)
  odac_sync #(.RESET_VALUE(1'b1)) uLoadSync (
    .clk(clk),
    .rst_n(rst_n),
    .pinIn(hw_load_n),
    .levelOut(loadLevel)
  );

  // frame tracking: execute once per rising chip select
  always_comb begin
    next_state = state;
    case (state)
      ODAC_IDLE: begin
        if (!csLevel) begin
          next_state = ODAC_FRAME;
        end
      end
      ODAC_FRAME: begin
        if (csLevel) begin
          next_state = ODAC_EXEC;
        end
      end
      ODAC_EXEC: begin
        next_state = ODAC_IDLE;
      end
      default: begin
        next_state = ODAC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ODAC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // word is quiet in the link domain while chip select is high, so sample it then
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd <= '0;
    end else if (state == ODAC_FRAME && csLevel) begin
      cmd <= odac_split(shiftWord);
    end
  end

  // input registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < CHANNELS; i++) begin
        inReg[i] <= ODAC_CODE_RST;
      end
    end else if (state == ODAC_EXEC) begin
      case (cmd.ctrl)
        ODAC_CMD_CLEAR: begin
          for (int i = 0; i < CHANNELS; i++) begin
            inReg[i] <= ODAC_CODE_RST;
          end
        end
        ODAC_CMD_LOADIN, ODAC_CMD_LOADBOTH: begin
          inReg[cmd.channelSelect] <= cmd.payloadByte;
        end
        default: begin
          // pass-through and others leave inputs alone
        end
      endcase
    end
  end

  // dac registers; transparent load follows inputs after any command
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < CHANNELS; i++) begin
        dacReg[i] <= ODAC_CODE_RST;
      end
    end else if (state == ODAC_EXEC) begin
      case (cmd.ctrl)
        ODAC_CMD_CLEAR: begin
          for (int i = 0; i < CHANNELS; i++) begin
            dacReg[i] <= ODAC_CODE_RST;
          end
        end
        ODAC_CMD_PHASE, ODAC_CMD_SWLOAD: begin
          for (int i = 0; i < CHANNELS; i++) begin
            dacReg[i] <= inReg[i];
          end
        end
        ODAC_CMD_LOADALL: begin
          for (int i = 0; i < CHANNELS; i++) begin
            dacReg[i] <= cmd.payloadByte;
          end
        end
        ODAC_CMD_LOADBOTH: begin
          dacReg[cmd.channelSelect] <= cmd.payloadByte;
        end
        default: begin
          if (!loadLevel) begin
            for (int i = 0; i < CHANNELS; i++) begin
              dacReg[i] <= inReg[i];
            end
          end
        end
      endcase
    end else if (!loadLevel) begin
      // one clk behind an input update; inputs only move in exec
      for (int i = 0; i < CHANNELS; i++) begin
        dacReg[i] <= inReg[i];
      end
    end
  end

  // shutdown and buffer mask
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shutdown <= 1'b0;
      bufMask <= ODAC_MASK_RST;
    end else if (state == ODAC_EXEC) begin
      case (cmd.ctrl)
        ODAC_CMD_SHDN: begin
          shutdown <= 1'b1;
          bufMask <= cmd.payloadByte;
        end
        ODAC_CMD_CLEAR, ODAC_CMD_LOADALL, ODAC_CMD_LOADBOTH: begin
          shutdown <= 1'b0;
          bufMask <= ODAC_MASK_RST;
        end
        default: begin
        end
      endcase
    end
  end

  // output phase latch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phaseRise <= ODAC_PHASE_RST;
    end else if (state == ODAC_EXEC && cmd.ctrl == ODAC_CMD_PHASE) begin
      phaseRise <= cmd.channelSelect[2];
    end
  end

  // flatten register arrays onto ports
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      dacCode[i*8 +: 8] = dacReg[i];
      inputCode[i*8 +: 8] = inReg[i];
    end
  end

  assign bufferEnable = shutdown ? bufMask : {CHANNELS{1'b1}};
endmodule : odac_core

// ==== odac_core_assertions.sv ====
// odac_core_assertions: port checks of the octal dac decoder
// assumes: bound to odac_core, sees only its ports
`timescale 1ns/1ps
module odac_core_assertions
  import odac_pkg::*;
#(
  parameter int CHANNELS = ODAC_CHANNELS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic csN,
  input wire logic sdi,
  input wire logic hw_load_n,
  input wire logic sdo,
  input wire logic [CHANNELS*8-1:0] dacCode,
  input wire logic [CHANNELS*8-1:0] inputCode,
  input wire logic [CHANNELS-1:0] bufferEnable,
  input wire logic shutdown,
  input wire logic phaseRise
);
  logic csPrev;
  logic [3:0] age;
  logic [3:0] hwAge;
  logic cmdWin;
  // clk cycles since chip select rose, saturating; sync delay sets the window
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      csPrev <= 1'b1;
      age <= 4'hf;
    end else begin
      csPrev <= csN;
      age <= (csN && !csPrev) ? 4'h0 : (age == 4'hf ? age : age + 4'h1);
    end
  end
  // clk cycles since hardware load was last low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hwAge <= 4'hf;
    end else begin
      hwAge <= !hw_load_n ? 4'h0 : (hwAge == 4'hf ? hwAge : hwAge + 4'h1);
    end
  end
  assign cmdWin = age >= 4'h2 && age <= 4'h9;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sdo_hold_a: assert property (csN && $past(csN) |-> $stable(sdo))
    else $error("sdo moved with chip select high");
  cs_quiet_a: assert property ((!csN)[*8] |-> $stable(inputCode) && $stable(shutdown))
    else $error("state moved inside a frame");
  buf_on_a: assert property (!shutdown |-> bufferEnable == {CHANNELS{1'b1}})
    else $error("buffer off outside shutdown");
  hw_follow_a: assert property ((!hw_load_n)[*6] |-> dacCode == $past(inputCode))
    else $error("dac not following input");
  in_win_a: assert property ($changed(inputCode) |-> cmdWin)
    else $error("input code moved outside command");
  dac_win_a: assert property ($changed(dacCode) |-> cmdWin || hwAge < 4'h8)
    else $error("dac code moved without cause");
  shdn_win_a: assert property ($changed(shutdown) |-> cmdWin)
    else $error("shutdown moved without command");
  phase_win_a: assert property ($changed(phaseRise) |-> cmdWin)
    else $error("phase moved without command");
  cover property ($rose(shutdown));
  cover property ($rose(phaseRise));
  cover property ((!hw_load_n)[*6] ##1 $changed(dacCode));
endmodule : odac_core_assertions

bind odac_core odac_core_assertions #(.CHANNELS(CHANNELS)) odac_core_assertions_inst (
  .clk(clk), .rst_n(rst_n), .sclk(sclk), .csN(csN), .sdi(sdi), .hw_load_n(hw_load_n),
  .sdo(sdo), .dacCode(dacCode), .inputCode(inputCode), .bufferEnable(bufferEnable),
  .shutdown(shutdown), .phaseRise(phaseRise));

// ==== odac_host.sv ====
// odac_host: host side of the serial link, one 16-bit frame per go pulse
// assumes: sclk runs at 30 ns only inside frames and idles low
`timescale 1ns/1ps
module odac_host (
  input wire logic go,
  input wire logic [15:0] word,
  input wire logic phaseRise,
  input wire logic sdo,
  output logic csN,
  output logic sclk,
  output logic sdi,
  output logic [15:0] rxWord
);
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
    rxWord = 16'h0000;
  end
  // whole word msb first; sdo sampled on the edge opposite its launch
  always @(posedge go) begin
    #7 csN = 1'b0;
    #40;
    for (int i = 15; i >= 0; i--) begin
      sdi = word[i];
      #15 sclk = 1'b1;
      if (!phaseRise) rxWord = {rxWord[14:0], sdo};
      #15 sclk = 1'b0;
      if (phaseRise) rxWord = {rxWord[14:0], sdo};
    end
    #15 csN = 1'b1;
    sdi = ~sdi; // released line must not look like a held bit
  end
endmodule : odac_host

// ==== odac_link.sv ====
// odac_link: serial shift register and serial output on the link clock; the word is captured in the core domain
// assumes: sclk only toggles inside frames; csN is a raw pin sampled on sclk
`timescale 1ns/1ps
module odac_link
  import odac_pkg::*;
(
  input wire logic sclk,
  input wire logic rst_n,
  input wire logic csN,
  input wire logic sdi,
  input wire logic phaseRise,
  output logic sdo,
  output logic [15:0] shiftWord
);
  logic riseBit;
  logic fallBit;

  // bits shift in msb first on rising sclk while selected
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      shiftWord <= 16'h0000;
    end else if (!csN) begin
      shiftWord <= {shiftWord[14:0], sdi};
    end
  end

  // rising-edge output copy: 16 cycles after input
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      riseBit <= 1'b0;
    end else if (!csN) begin
      riseBit <= shiftWord[15];
    end
  end

  // falling-edge output copy adds the half cycle
  always_ff @(negedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      fallBit <= 1'b0;
    end else if (!csN) begin
      fallBit <= riseBit; // half a cycle behind the rising copy
    end
  end

  // always driven, frozen while deselected since both copies hold
  assign sdo = phaseRise ? riseBit : fallBit;
endmodule : odac_link

// ==== odac_pkg.sv ====
// odac_pkg: command word layout, control codes and shared types of the octal dac decoder
// assumes: 16-bit words shifted msb first, one command per chip-select frame
package odac_pkg;
  localparam int ODAC_WORD_BITS = 16;
  localparam int ODAC_DATA_BITS = 8;
  localparam int ODAC_CHANNELS = 8;
  // field positions inside the shifted word
  localparam int ODAC_DATA_LSB = 0;
  localparam int ODAC_CTRL_LSB = 8;
  localparam int ODAC_ADDR_LSB = 11;
  // control codes (ctrl_bit_2..ctrl_bit_0)
  localparam logic [2:0] ODAC_CMD_PASS = 3'h0;
  localparam logic [2:0] ODAC_CMD_CLEAR = 3'h1;
  localparam logic [2:0] ODAC_CMD_SHDN = 3'h2;
  localparam logic [2:0] ODAC_CMD_PHASE = 3'h3;
  localparam logic [2:0] ODAC_CMD_LOADALL = 3'h4;
  localparam logic [2:0] ODAC_CMD_LOADIN = 3'h5;
  localparam logic [2:0] ODAC_CMD_LOADBOTH = 3'h6;
  localparam logic [2:0] ODAC_CMD_SWLOAD = 3'h7;
  // reset values
  localparam logic [7:0] ODAC_CODE_RST = 8'h00;
  localparam logic [7:0] ODAC_MASK_RST = 8'hff;
  localparam logic ODAC_PHASE_RST = 1'b0;

  // decoded command word handed from link domain to core domain
  typedef struct packed {
    logic [2:0] channelSelect;
    logic [2:0] ctrl;
    logic [7:0] payloadByte;
  } odac_cmd_s;

  function automatic odac_cmd_s odac_split(input logic [15:0] word);
    odac_cmd_s c;
    c.channelSelect = word[ODAC_ADDR_LSB +: 3];
    c.ctrl = word[ODAC_CTRL_LSB +: 3];
    c.payloadByte = word[ODAC_DATA_LSB +: 8];
    return c;
  endfunction : odac_split
endpackage : odac_pkg

// ==== odac_sync.sv ====
// odac_sync: three-stage synchroniser with agreement filter for pin levels
// assumes: input is asynchronous to clk; output changes when stages two and three agree
`timescale 1ns/1ps
module odac_sync
  import odac_pkg::*;
#(
  parameter logic RESET_VALUE = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pinIn,
  output logic levelOut
);
  logic stage1;
  logic stage2;
  logic stage3;

  // stage1 feeds stage2 only, metastability stays off the filter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= RESET_VALUE;
      stage2 <= RESET_VALUE;
      stage3 <= RESET_VALUE;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // level only moves once two stages agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      levelOut <= RESET_VALUE;
    end else if (stage2 == stage3) begin
      levelOut <= stage3;
    end
  end
endmodule : odac_sync

// ==== tb_top.sv ====
// tb_top: drives odac_core through the host model, checks against a queue
// assumes: host model frames words; notes are compared when show is seen
`timescale 1ns/1ps
module tb_top;
  import odac_pkg::*;
  typedef struct packed {
    logic [63:0] dac;
    logic [63:0] inp;
    logic [7:0] en;
    logic [1:0] st;
    logic [15:0] rx;
  } odac_note_s;
  logic clk, rst_n, hwLoadN, go, show, csN, sclk, sdi, sdo, shutdown, phaseRise;
  logic [15:0] word, rxWord, prev, prev2, expRx;
  logic [63:0] dacCode, inputCode, mIn, mDac;
  logic [7:0] bufferEnable, mMask, r;
  logic mShd, mPh, lastPh;
  int errors, checked;
  int seed = 32'h4549;
  odac_note_s q[$];
  odac_note_s n;
  always #5 clk = ~clk;
  odac_core odac_core_inst (.clk(clk), .rst_n(rst_n), .sclk(sclk), .csN(csN), .sdi(sdi),
    .hw_load_n(hwLoadN), .sdo(sdo), .dacCode(dacCode), .inputCode(inputCode),
    .bufferEnable(bufferEnable), .shutdown(shutdown), .phaseRise(phaseRise));
  odac_host odac_host_inst (.go(go), .word(word), .phaseRise(mPh), .sdo(sdo),
    .csN(csN), .sclk(sclk), .sdi(sdi), .rxWord(rxWord));
  task automatic stop_test();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test
  task automatic chk(input string s, input logic [63:0] e, input logic [63:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // bounded wait for chip select level; a hang ends the run
  task automatic waitcs(input logic v);
    int k;
    k = 0;
    while (csN !== v && k < 200) begin
      @(posedge clk);
      k++;
    end
    if (k == 200) begin
      errors++;
      stop_test();
    end
  endtask : waitcs
  // settle past the 5-7 clk command latency, then hand the note over
  task automatic note();
    repeat (10) @(posedge clk);
    q.push_back({mDac, mIn, mShd ? mMask : 8'hff, mShd, mPh, expRx});
    show <= 1'b1;
    @(posedge clk);
    show <= 1'b0;
  endtask : note
  task automatic dorst();
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    mIn = '0;
    mDac = '0;
    mShd = 1'b0;
    mPh = ODAC_PHASE_RST;
    prev = '0;
    prev2 = '0;
    lastPh = 1'b0;
    note();
  endtask : dorst
  // one frame, then the expected state worked out from the command
  task automatic cmd(input logic [2:0] c, input logic [2:0] a, input logic [7:0] d);
    word <= {2'b10, a, c, d};
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    waitcs(1'b0);
    waitcs(1'b1);
    // falling phase shows the older word's last bit first; the sclk-side phase copy
    // needs two sclk rises, so the first rising-phase frame drops one bit
    if (!mPh) expRx = {prev2[0], prev[15:1]};
    else if (lastPh) expRx = prev;
    else expRx = {prev2[0], prev[14:0]};
    lastPh = mPh;
    prev2 = prev;
    prev = {2'b10, a, c, d};
    if (c == ODAC_CMD_LOADIN || c == ODAC_CMD_LOADBOTH) mIn[a*8 +: 8] = d;
    if (c == ODAC_CMD_CLEAR) mIn = '0;
    if (c inside {ODAC_CMD_CLEAR, ODAC_CMD_PHASE, ODAC_CMD_SWLOAD} || !hwLoadN) mDac = mIn;
    if (c == ODAC_CMD_LOADBOTH) mDac[a*8 +: 8] = d;
    if (c == ODAC_CMD_LOADALL) mDac = {8{d}};
    if (c == ODAC_CMD_PHASE) mPh = a[2];
    if (c == ODAC_CMD_SHDN) mMask = d;
    mShd = c == ODAC_CMD_SHDN ||
      mShd && !(c inside {ODAC_CMD_CLEAR, ODAC_CMD_LOADALL, ODAC_CMD_LOADBOTH});
    note();
  endtask : cmd
  function automatic logic [7:0] rnd();
    logic [31:0] v;
    v = $random(seed);
    return v[7:0];
  endfunction : rnd
  // compare the oldest note with the outputs when show is seen
  always @(posedge clk) begin
    if (show && q.size() > 0) begin
      n = q.pop_front();
      chk("dac", n.dac, dacCode);
      chk("inp", n.inp, inputCode);
      chk("en", {56'h0, n.en}, {56'h0, bufferEnable});
      chk("st", {62'h0, n.st}, {62'h0, shutdown, phaseRise});
      chk("rx", {48'h0, n.rx}, {48'h0, rxWord});
    end
  end
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    hwLoadN = 1'b1;
    go = 1'b0;
    show = 1'b0;
    word = 16'h0000;
    expRx = 16'h0000;
    errors = 0;
    checked = 0;
    dorst();
    for (int i = 0; i < 8; i++) cmd(ODAC_CMD_LOADIN, i[2:0], rnd());
    for (int c = 0; c < 16; c++) begin
      r = rnd();
      cmd(c[2:0], r[2:0], rnd());
    end
    cmd(ODAC_CMD_SHDN, 3'h0, rnd());
    cmd(ODAC_CMD_LOADIN, 3'h5, rnd());
    cmd(ODAC_CMD_PHASE, 3'h4, 8'h00);
    cmd(ODAC_CMD_PASS, 3'h1, rnd());
    cmd(ODAC_CMD_LOADBOTH, 3'h7, rnd());
    cmd(ODAC_CMD_PHASE, 3'h0, 8'h00);
    hwLoadN <= 1'b0;
    mDac = mIn;
    cmd(ODAC_CMD_LOADIN, 3'h2, rnd());
    hwLoadN <= 1'b1;
    cmd(ODAC_CMD_LOADALL, 3'h3, 8'h00);
    dorst();
    cmd(ODAC_CMD_PASS, 3'h0, 8'h00);
    stop_test();
  end
endmodule : tb_top
